// file: rtl/dpc_consts.svh
// Register map, field positions, reset values and fixed coefficients of the playback path control
`ifndef DPC_CONSTS_SVH
`define DPC_CONSTS_SVH

// ****************************************************************
// Register indices (byte address is index shifted left by two)
// ****************************************************************
`define DPC_IDX_CTRL      8'h30
`define DPC_IDX_LEFT      8'h32
`define DPC_IDX_RIGHT     8'h33
`define DPC_IDX_RATE      8'h35
`define DPC_IDX_STATUS    8'h37
`define DPC_ADR_SHIFT     2

// ****************************************************************
// Field positions
// ****************************************************************
`define DPC_BIT_MONO      13
`define DPC_BIT_RATIO     12
`define DPC_BIT_DEEMPHASIS_SEL_HI  5
`define DPC_BIT_DEEMPHASIS_SEL_LO  4
`define DPC_BIT_FAST      3
`define DPC_BIT_LINV      1
`define DPC_BIT_RINV      0
`define DPC_BIT_CHON      15
`define DPC_BIT_COMMIT    8
`define DPC_BIT_GAIN_HI   7
`define DPC_BIT_FCGEN     11
`define DPC_BIT_PERIOD_HI 10
`define DPC_BIT_ST_LRCLK  0
`define DPC_BIT_ST_RUN    1
`define DPC_BIT_ST_PEND   2

// ****************************************************************
// Reset values and masks
// ****************************************************************
`define DPC_CTRL_RST      16'h0000
`define DPC_CTRL_MASK     16'h303b
`define DPC_RATE_RST      16'h0040
`define DPC_RATE_MASK     16'h0fff
`define DPC_GAIN_RST      8'hc0
`define DPC_PERIOD_MIN    11'h008

// ****************************************************************
// Gain law: code 192 is unity, 0.375 dB per code, 16 fraction bits
// ****************************************************************
`define DPC_ZERO_DB_CODE  192
`define DPC_STEP_DB       0.375
`define DPC_UNITY_REAL    65536.0
`define DPC_UNITY_GAIN    24'h010000
`define DPC_GAIN_FRAC     16

// ****************************************************************
// De-emphasis one-pole coefficients, out of 256
// ****************************************************************
`define DPC_DEEMPH_K32    9'h0a0
`define DPC_DEEMPH_K44    9'h0b8
`define DPC_DEEMPH_K48    9'h0c0
`define DPC_DEEMPH_SHIFT  8
`define DPC_DEEMPH_UNITY  9'h100

`endif

// file: rtl/dpc_pkg.sv
// Types shared by the playback path control modules
package dpc_pkg;

	// De-emphasis selection codes
	typedef enum logic [1:0]
	{
		DPC_DE_NONE = 2'h0,
		DPC_DE_32K  = 2'h1,
		DPC_DE_44K  = 2'h2,
		DPC_DE_48K  = 2'h3
	} dpc_deemph_t;

	// Frame clock generator states, one-hot
	typedef enum logic [1:0]
	{
		DPC_FC_IDLE = 2'b01,
		DPC_FC_RUN  = 2'b10
	} dpc_fc_state_t;

endpackage

// file: rtl/dpc_gain_rom.sv
// Gain lookup table: gain code to linear multiplier, registered read
`timescale 1ns/1ps
`include "dpc_consts.svh"

module dpc_gain_rom #(
	parameter int GAIN_W = 24
) (
	input  wire logic              core_clk,
	input  wire logic [7:0]        rdAddr,
	output logic      [GAIN_W-1:0] rdData
);

	// ****************************************************************
	// Table contents
	// ****************************************************************

	// Code 0 is a hard mute; above 0 dB the same step keeps going
	function automatic logic [GAIN_W-1:0] gainEntry(input int code);
		real db;
		real lin;
		db = 0.0;
		lin = 0.0;
		if (code == 0)
			return '0;
		db = real'(code - `DPC_ZERO_DB_CODE) * `DPC_STEP_DB;
		lin = 10.0 ** (db / 20.0);
		return GAIN_W'($rtoi(lin * `DPC_UNITY_REAL));
	endfunction

	logic [GAIN_W-1:0] tbl [256];

	if (GAIN_W < 21)
		$error("dpc_gain_rom: GAIN_W too narrow for +23.6 dB codes");

	// One constant per entry, filled at elaboration
	for (genvar i = 0; i < 256; i++)
	begin : g_tbl
		assign tbl[i] = gainEntry(i);
	end

	// ****************************************************************
	// Read port
	// ****************************************************************

	// Read data registered so the multiplier sees a clean operand
	always_ff @(posedge core_clk)
	begin
		rdData <= tbl[rdAddr];
	end

	a_unity_entry: assert property (@(posedge core_clk) rdAddr == `DPC_GAIN_RST |=> rdData == `DPC_UNITY_GAIN)
		else $error("unity code does not give unity gain");
	a_mute_entry: assert property (@(posedge core_clk) rdAddr == 8'h00 |=> rdData == '0)
		else $error("code zero does not mute");
	a_step_rise: assert property (@(posedge core_clk) rdAddr == 8'h01 ##1 rdAddr == 8'h02 |=>
		rdData > $past(rdData))
		else $error("gain does not rise with code");

endmodule

// file: rtl/dpc_frame_clock_gen.sv
// Master-mode left/right frame clock generator counting bit clocks per phase
`timescale 1ns/1ps
`include "dpc_consts.svh"

module dpc_frame_clock_gen #(
	parameter int PERIOD_W = 11
) (
	input  wire logic                core_clk,
	input  wire logic                sys_rst,
	input  wire logic                genOn,
	input  wire logic                masterMode,
	input  wire logic                bitClkTick,
	input  wire logic [PERIOD_W-1:0] period,
	output logic                     lrFrameClock,
	output logic                     running
);

	if (PERIOD_W < 4)
		$error("dpc_frame_clock_gen: PERIOD_W cannot hold the minimum period");

	dpc_pkg::dpc_fc_state_t stateReg;
	dpc_pkg::dpc_fc_state_t stateNext;
	logic [PERIOD_W-1:0]    cntReg;
	logic [PERIOD_W-1:0]    cntNext;
	logic                   clkReg;
	logic                   clkNext;
	logic [PERIOD_W-1:0]    effPeriod;
	logic                   active;

	// ****************************************************************
	// Phase counter
	// ****************************************************************

	// Periods under the minimum are invalid; they run at the minimum instead
	always_comb
	begin
		active = genOn && masterMode;
		effPeriod = (period < PERIOD_W'(`DPC_PERIOD_MIN)) ? PERIOD_W'(`DPC_PERIOD_MIN) : period;
		stateNext = stateReg;
		cntNext = cntReg;
		clkNext = clkReg;
		unique case (stateReg)
			dpc_pkg::DPC_FC_IDLE:
			begin
				cntNext = '0;
				clkNext = 1'b0;
				if (active)
					stateNext = dpc_pkg::DPC_FC_RUN;
			end
			dpc_pkg::DPC_FC_RUN:
			begin
				if (!active)
				begin
					stateNext = dpc_pkg::DPC_FC_IDLE;
					cntNext = '0;
					clkNext = 1'b0;
				end
				else if (bitClkTick)
				begin
					// Wrap also when the period shrank below the count
					if (cntReg >= effPeriod - PERIOD_W'(1))
					begin
						cntNext = '0;
						clkNext = !clkReg;
					end
					else
						cntNext = cntReg + PERIOD_W'(1);
				end
			end
			default:
			begin
				stateNext = dpc_pkg::DPC_FC_IDLE;
				cntNext = '0;
				clkNext = 1'b0;
			end
		endcase
	end

	// State registers
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			stateReg <= dpc_pkg::DPC_FC_IDLE;
			cntReg <= '0;
			clkReg <= 1'b0;
		end
		else
		begin
			stateReg <= stateNext;
			cntReg <= cntNext;
			clkReg <= clkNext;
		end
	end

	assign lrFrameClock = clkReg;
	assign running = (stateReg == dpc_pkg::DPC_FC_RUN);

	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_gen_idle_low: assert property (!(genOn && masterMode) |=> !lrFrameClock)
		else $error("frame clock runs while generation is off");
	a_phase_toggle: assert property (running && active && bitClkTick && cntReg == effPeriod - PERIOD_W'(1)
		|=> lrFrameClock != $past(lrFrameClock))
		else $error("frame clock phase did not end at the period");
	a_phase_hold: assert property (running && active && !bitClkTick |=> $stable(lrFrameClock))
		else $error("frame clock moved without a bit clock");

endmodule

// file: rtl/dpc_digital_path.sv
// Playback path control: register file on classic Wishbone and the sample processing pipeline
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "dpc_consts.svh"

// Behaviour
// - Mono bit: both outputs carry half the sum
// - Ratio bit: one is 272 Fs, zero 256 Fs
// - De-emphasis code: off, 32k, 44.1k, 48k curves
// - Fast bit runs modulator above 64 Fs
// - Per-channel polarity bit negates that channel
// - Channel enable at bit 15, resets off
// - Gains apply together on commit bit write
// - Gain code: 0 mute, 0.375 dB steps
// - Frame clock generated only when bit 11 set
// - Period field 8 to 2047 bit clocks
module dpc_digital_path #(
	parameter int SAMPLE_W = 16,
	parameter int GAIN_W   = 24,
	parameter int PERIOD_W = 11
) (
	input  wire logic                core_clk,
	input  wire logic                sys_rst,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [31:0]         wb_dat_i,
	input  wire logic [3:0]          wb_sel_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	input  wire logic [SAMPLE_W-1:0] sampleLeft,
	input  wire logic [SAMPLE_W-1:0] sampleRight,
	input  wire logic                sampleValid,
	input  wire logic                masterMode,
	input  wire logic                bitClkTick,
	output logic      [SAMPLE_W-1:0] outLeft,
	output logic      [SAMPLE_W-1:0] outRight,
	output logic                     outValid,
	output logic                     monoActive,
	output logic                     frameClockRatioSel,
	output logic      [1:0]          deemphasisSel,
	output logic                     modulatorFastClk,
	output logic                     lrFrameClock
);

	localparam int PW = SAMPLE_W + GAIN_W + 1;
	localparam int DW = SAMPLE_W + 10;
	localparam logic signed [PW-1:0] SMAX = (PW'(1) <<< (SAMPLE_W - 1)) - PW'(1);
	localparam logic signed [PW-1:0] SMIN = -(PW'(1) <<< (SAMPLE_W - 1));
	localparam logic [SAMPLE_W-1:0]  NEG_FULL = {1'b1, {(SAMPLE_W - 1){1'b0}}};

	if (SAMPLE_W < 8 || SAMPLE_W > 24)
		$error("dpc_digital_path: SAMPLE_W must be 8 to 24");
	if (PERIOD_W != 11)
		$error("dpc_digital_path: PERIOD_W must match the 11-bit field");

	// ****************************************************************
	// Register file
	// ****************************************************************

	logic [15:0]   ctrlReg, ctrlNext;
	logic [15:0]   rateReg, rateNext;
	logic          leftOnReg, leftOnNext, rightOnReg, rightOnNext;
	logic [7:0]    leftPendReg, leftPendNext, rightPendReg, rightPendNext;
	logic [7:0]    leftAppliedReg, leftAppliedNext, rightAppliedReg, rightAppliedNext;
	logic          ackReg, ackNext;
	logic [31:0]   rdataReg, rdataNext;
	logic          fcRunning;
	logic          req, wr, hitCtrl, hitLeft, hitRight, hitRate, hitStatus, commitNow;
	logic [7:0]    regIdx;
	logic [15:0]   leftWord, rightWord, statusWord;

	// Byte-lane merge of a 16-bit register with a write
	function automatic logic [15:0] laneMerge(input logic [15:0] old, input logic [31:0] dat, input logic [3:0] sel);
		logic [15:0] res;
		res = old;
		if (sel[0])
			res[7:0] = dat[7:0];
		if (sel[1])
			res[15:8] = dat[15:8];
		return res;
	endfunction

	// Decode; the low two address bits are ignored, unmapped words read zero
	always_comb
	begin
		req = wb_cyc_i && wb_stb_i && !ackReg;
		wr = req && wb_we_i;
		regIdx = 8'(wb_adr_i >> `DPC_ADR_SHIFT);
		hitCtrl = (regIdx == `DPC_IDX_CTRL);
		hitLeft = (regIdx == `DPC_IDX_LEFT);
		hitRight = (regIdx == `DPC_IDX_RIGHT);
		hitRate = (regIdx == `DPC_IDX_RATE);
		hitStatus = (regIdx == `DPC_IDX_STATUS);
		// Either gain register carries the shared commit strobe
		commitNow = wr && (hitLeft || hitRight) && wb_sel_i[1] && wb_dat_i[`DPC_BIT_COMMIT];
		leftWord = {leftOnReg, 7'h00, leftPendReg};
		rightWord = {rightOnReg, 7'h00, rightPendReg};
		statusWord = 16'h0000;
		statusWord[`DPC_BIT_ST_LRCLK] = lrFrameClock;
		statusWord[`DPC_BIT_ST_RUN] = fcRunning;
		statusWord[`DPC_BIT_ST_PEND] = (leftPendReg != leftAppliedReg) || (rightPendReg != rightAppliedReg);
	end

	// Next register values; commit takes the word written in the same access
	always_comb
	begin
		logic [15:0] mergedL;
		logic [15:0] mergedR;
		mergedL = laneMerge(leftWord, wb_dat_i, wb_sel_i);
		mergedR = laneMerge(rightWord, wb_dat_i, wb_sel_i);
		ctrlNext = ctrlReg;
		rateNext = rateReg;
		leftOnNext = leftOnReg;
		rightOnNext = rightOnReg;
		leftPendNext = leftPendReg;
		rightPendNext = rightPendReg;
		if (wr && hitCtrl)
			ctrlNext = laneMerge(ctrlReg, wb_dat_i, wb_sel_i) & `DPC_CTRL_MASK;
		if (wr && hitRate)
			rateNext = laneMerge(rateReg, wb_dat_i, wb_sel_i) & `DPC_RATE_MASK;
		if (wr && hitLeft)
		begin
			leftOnNext = mergedL[`DPC_BIT_CHON];
			leftPendNext = mergedL[`DPC_BIT_GAIN_HI:0];
		end
		if (wr && hitRight)
		begin
			rightOnNext = mergedR[`DPC_BIT_CHON];
			rightPendNext = mergedR[`DPC_BIT_GAIN_HI:0];
		end
		leftAppliedNext = commitNow ? leftPendNext : leftAppliedReg;
		rightAppliedNext = commitNow ? rightPendNext : rightAppliedReg;
		ackNext = req;
		rdataNext = 32'h00000000;
		if (req && !wb_we_i)
		begin
			unique case (1'b1)
				hitCtrl:   rdataNext = {16'h0000, ctrlReg};
				hitLeft:   rdataNext = {16'h0000, leftWord};
				hitRight:  rdataNext = {16'h0000, rightWord};
				hitRate:   rdataNext = {16'h0000, rateReg};
				hitStatus: rdataNext = {16'h0000, statusWord};
				default:   rdataNext = 32'h00000000;
			endcase
		end
	end

	// Register state; enables and gains come out of reset at their defaults
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			ctrlReg <= `DPC_CTRL_RST;
			rateReg <= `DPC_RATE_RST;
			leftOnReg <= 1'b0;
			rightOnReg <= 1'b0;
			leftPendReg <= `DPC_GAIN_RST;
			rightPendReg <= `DPC_GAIN_RST;
			leftAppliedReg <= `DPC_GAIN_RST;
			rightAppliedReg <= `DPC_GAIN_RST;
			ackReg <= 1'b0;
			rdataReg <= 32'h00000000;
		end
		else
		begin
			ctrlReg <= ctrlNext;
			rateReg <= rateNext;
			leftOnReg <= leftOnNext;
			rightOnReg <= rightOnNext;
			leftPendReg <= leftPendNext;
			rightPendReg <= rightPendNext;
			leftAppliedReg <= leftAppliedNext;
			rightAppliedReg <= rightAppliedNext;
			ackReg <= ackNext;
			rdataReg <= rdataNext;
		end
	end

	assign wb_ack_o = ackReg;
	assign wb_dat_o = rdataReg;
	assign frameClockRatioSel = ctrlReg[`DPC_BIT_RATIO];
	assign deemphasisSel = ctrlReg[`DPC_BIT_DEEMPHASIS_SEL_HI:`DPC_BIT_DEEMPHASIS_SEL_LO];
	assign modulatorFastClk = ctrlReg[`DPC_BIT_FAST];

	// ****************************************************************
	// Gain tables and frame clock
	// ****************************************************************

	logic [GAIN_W-1:0] romLeft, romRight;

	dpc_gain_rom #(.GAIN_W(GAIN_W)) u_rom_left (
		.core_clk (core_clk),
		.rdAddr   (leftAppliedReg),
		.rdData   (romLeft)
	);

	dpc_gain_rom #(.GAIN_W(GAIN_W)) u_rom_right (
		.core_clk (core_clk),
		.rdAddr   (rightAppliedReg),
		.rdData   (romRight)
	);

	dpc_frame_clock_gen #(.PERIOD_W(PERIOD_W)) u_fclk (
		.core_clk     (core_clk),
		.sys_rst      (sys_rst),
		.genOn        (rateReg[`DPC_BIT_FCGEN]),
		.masterMode   (masterMode),
		.bitClkTick   (bitClkTick),
		.period       (rateReg[`DPC_BIT_PERIOD_HI:0]),
		.lrFrameClock (lrFrameClock),
		.running      (fcRunning)
	);

	// ****************************************************************
	// Sample pipeline
	// ****************************************************************

	logic signed [SAMPLE_W-1:0] s1LReg, s1LNext, s1RReg, s1RNext;
	logic signed [SAMPLE_W-1:0] mix2LReg, mix2LNext, mix2RReg, mix2RNext;
	logic signed [SAMPLE_W-1:0] outLReg, outLNext, outRReg, outRNext;
	logic                       valid1Reg, valid2Reg, valid2Next, outValidReg, mono2Reg, mono2Next;

	// Negation that keeps full-scale negative from wrapping
	function automatic logic [SAMPLE_W-1:0] negSat(input logic [SAMPLE_W-1:0] x);
		return (x == NEG_FULL) ? ~NEG_FULL : SAMPLE_W'(-$signed(x));
	endfunction

	// Gain multiply with saturation; a disabled or muted channel yields zero
	function automatic logic signed [SAMPLE_W-1:0] applyGain(input logic signed [SAMPLE_W-1:0] x,
		input logic [GAIN_W-1:0] g, input logic on, input logic [7:0] code);
		logic signed [PW-1:0] prod;
		prod = PW'(x) * $signed(PW'({1'b0, g}));
		prod = prod >>> `DPC_GAIN_FRAC;
		if (!on || code == 8'h00)
			return '0;
		if (prod > SMAX)
			return SAMPLE_W'(SMAX);
		if (prod < SMIN)
			return SAMPLE_W'(SMIN);
		return SAMPLE_W'(prod);
	endfunction

	// One-pole shelving per selected rate; off passes the sample straight
	function automatic logic signed [SAMPLE_W-1:0] deemph(input logic signed [SAMPLE_W-1:0] x,
		input logic signed [SAMPLE_W-1:0] yPrev, input logic [1:0] sel);
		logic [8:0]           k;
		logic signed [DW-1:0] step;
		k = `DPC_DEEMPH_K48;
		unique case (dpc_pkg::dpc_deemph_t'(sel))
			dpc_pkg::DPC_DE_NONE: k = `DPC_DEEMPH_UNITY;
			dpc_pkg::DPC_DE_32K:  k = `DPC_DEEMPH_K32;
			dpc_pkg::DPC_DE_44K:  k = `DPC_DEEMPH_K44;
			dpc_pkg::DPC_DE_48K:  k = `DPC_DEEMPH_K48;
		endcase
		step = (DW'(x) - DW'(yPrev)) * $signed(DW'({1'b0, k}));
		step = step >>> `DPC_DEEMPH_SHIFT;
		return SAMPLE_W'(DW'(yPrev) + step);
	endfunction

	// Stage values: polarity, gain and mono, then de-emphasis
	always_comb
	begin
		logic signed [SAMPLE_W-1:0] gL;
		logic signed [SAMPLE_W-1:0] gR;
		logic signed [SAMPLE_W:0]   sum;
		gL = applyGain(s1LReg, romLeft, leftOnReg, leftAppliedReg);
		gR = applyGain(s1RReg, romRight, rightOnReg, rightAppliedReg);
		sum = (SAMPLE_W + 1)'(gL) + (SAMPLE_W + 1)'(gR);
		s1LNext = ctrlReg[`DPC_BIT_LINV] ? negSat(sampleLeft) : sampleLeft;
		s1RNext = ctrlReg[`DPC_BIT_RINV] ? negSat(sampleRight) : sampleRight;
		mono2Next = ctrlReg[`DPC_BIT_MONO];
		mix2LNext = mono2Next ? SAMPLE_W'(sum >>> 1) : gL;
		mix2RNext = mono2Next ? SAMPLE_W'(sum >>> 1) : gR;
		valid2Next = valid1Reg;
		outLNext = valid2Reg ? deemph(mix2LReg, outLReg, deemphasisSel) : outLReg;
		outRNext = valid2Reg ? deemph(mix2RReg, outRReg, deemphasisSel) : outRReg;
	end

	// Pipeline registers; data only move with their valid to save toggling
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			s1LReg <= '0;
			s1RReg <= '0;
			mix2LReg <= '0;
			mix2RReg <= '0;
			outLReg <= '0;
			outRReg <= '0;
			valid1Reg <= 1'b0;
			valid2Reg <= 1'b0;
			outValidReg <= 1'b0;
			mono2Reg <= 1'b0;
		end
		else
		begin
			if (sampleValid)
			begin
				s1LReg <= s1LNext;
				s1RReg <= s1RNext;
			end
			if (valid1Reg)
			begin
				mix2LReg <= mix2LNext;
				mix2RReg <= mix2RNext;
				mono2Reg <= mono2Next;
			end
			outLReg <= outLNext;
			outRReg <= outRNext;
			valid1Reg <= sampleValid;
			valid2Reg <= valid2Next;
			outValidReg <= valid2Reg;
		end
	end

	assign outLeft = outLReg;
	assign outRight = outRReg;
	assign outValid = outValidReg;
	assign monoActive = ctrlReg[`DPC_BIT_MONO];

	// ****************************************************************
	// Checks
	// ****************************************************************

	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_mono_equal: assert property (valid2Reg && mono2Reg |-> mix2LReg == mix2RReg)
		else $error("mono outputs differ");
	a_ratio_write: assert property (wr && hitCtrl && wb_sel_i[1] |=> frameClockRatioSel == $past(wb_dat_i[12]))
		else $error("ratio select not taken from write");
	a_deemph_bypass: assert property (valid2Reg && deemphasisSel == 2'h0 |=> outValid && outLeft == $past(mix2LReg))
		else $error("de-emphasis off altered the sample");
	a_fast_write: assert property (wr && hitCtrl && wb_sel_i[0] |=> modulatorFastClk == $past(wb_dat_i[3]))
		else $error("fast modulator bit not taken from write");
	a_invert_left: assert property (sampleValid && ctrlReg[1] && sampleLeft != NEG_FULL
		|=> s1LReg == -$past($signed(sampleLeft)))
		else $error("left polarity not inverted");
	a_disabled_zero: assert property (valid1Reg && !leftOnReg && !ctrlReg[13] |=> mix2LReg == '0)
		else $error("disabled channel not silent");
	a_commit_hold: assert property (!commitNow |=> $stable(leftAppliedReg) && $stable(rightAppliedReg))
		else $error("gain changed without commit");
	a_mute_code: assert property (valid1Reg && rightAppliedReg == 8'h00 && !ctrlReg[13] |=> mix2RReg == '0)
		else $error("gain code zero not muted");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held over two cycles");

endmodule

// file: bench/dpc_sample_source.sv
// Host-side playback sample source for the path control bench
`timescale 1ns/1ps

module dpc_sample_source
(
	input  wire logic        core_clk,
	output logic      [15:0] sampleLeft,
	output logic      [15:0] sampleRight,
	output logic             sampleValid
);
	// Quiet lines at time zero
	initial
	begin
		sampleLeft  = 16'h0000;
		sampleRight = 16'h0000;
		sampleValid = 1'b0;
	end

	// One frame for a single cycle; afterwards the lines carry the inverse
	// so that stale data is never mistaken for a held sample
	task automatic send(input logic [15:0] l, input logic [15:0] r);
		@(posedge core_clk);
		sampleLeft  <= l;
		sampleRight <= r;
		sampleValid <= 1'b1;
		@(posedge core_clk);
		sampleLeft  <= ~l;
		sampleRight <= ~r;
		sampleValid <= 1'b0;
	endtask
endmodule

// file: bench/tb_dpc_digital_path.sv
// Self-checking bench for the playback path control
`timescale 1ns/1ps

module tb_dpc_digital_path;
	logic        core_clk = 1'b0;
	logic        sys_rst  = 1'b1;
	logic        wbCyc    = 1'b0;
	logic        wbStb    = 1'b0;
	logic        wbWe     = 1'b0;
	logic [7:0]  wbAdr    = 8'h00;
	logic [31:0] wbDatW   = 32'h0;
	logic [3:0]  wbSel    = 4'h0;
	logic [31:0] wbDatR, d;
	logic [15:0] sL, sR, oL, oR;
	logic [1:0]  deemphasis_sel;
	logic        wbAck, sV, oV, mono, ratio, fast, lrClk;
	logic        master   = 1'b0;
	logic        tick     = 1'b0;
	int          failures = 0;
	int          cmp_count = 0;
	int          n;

	// ****
	// Clock, source and device
	// ****
	always #50 core_clk = ~core_clk;

	dpc_sample_source u_src (.core_clk(core_clk), .sampleLeft(sL), .sampleRight(sR), .sampleValid(sV));

	dpc_digital_path u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDatW), .wb_sel_i(wbSel), .wb_dat_o(wbDatR),
		.wb_ack_o(wbAck), .sampleLeft(sL), .sampleRight(sR), .sampleValid(sV), .masterMode(master),
		.bitClkTick(tick), .outLeft(oL), .outRight(oR), .outValid(oV), .monoActive(mono),
		.frameClockRatioSel(ratio), .deemphasisSel(deemphasis_sel), .modulatorFastClk(fast), .lrFrameClock(lrClk));

	// ****
	// Checking and closing
	// ****
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Classic single cycle; held until ack is sampled, bounded wait
	task automatic wb(input logic we, input logic [7:0] adr, input logic [15:0] wd);
		@(posedge core_clk);
		wbCyc  <= 1'b1;
		wbStb  <= 1'b1;
		wbWe   <= we;
		wbAdr  <= adr;
		wbDatW <= {16'h0000, wd};
		wbSel  <= 4'h3;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (wbAck !== 1'b1 && n < 20);
		d = wbDatR;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe  <= 1'b0;
		wbSel <= 4'h0;
		if (wbAck !== 1'b1)
		begin
			failures++;
			end_of_test();
		end
	endtask

	// Extra edge lets mirrored control outputs settle before they are looked at
	task automatic wr(input logic [7:0] adr, input logic [15:0] wd);
		wb(1'b1, adr, wd);
		@(posedge core_clk);
	endtask

	task automatic rdc(input logic [7:0] adr, input logic [31:0] exp, input string nm);
		wb(1'b0, adr, 16'h0000);
		chk(nm, d, exp);
	endtask

	// One frame through the pipe, result expected three edges later
	task automatic smp(input logic [15:0] l, r, el, er);
		u_src.send(l, r);
		n = 0;
		while (oV !== 1'b1 && n < 10)
		begin
			@(posedge core_clk);
			n++;
		end
		chk("latency", n, 32'd3);
		chk("outLeft", oL, {16'h0000, el});
		chk("outRight", oR, {16'h0000, er});
	endtask

	// Counts bit clock ticks until the frame clock first goes high
	task automatic fc(input logic [15:0] w, input int exp);
		wr(8'hd4, w);
		n = 0;
		while (lrClk === 1'b0 && n < 40)
		begin
			@(posedge core_clk) tick <= 1'b1;
			@(posedge core_clk) tick <= 1'b0;
			@(posedge core_clk);
			n++;
		end
		chk("ticksPerPhase", n, 32'(exp));
		wr(8'hd4, 16'h0000);
	endtask

	// ****
	// Main sequence
	// ****
	initial
	begin
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		rdc(8'hc0, 32'h0000, "ctrlReset");
		rdc(8'hc8, 32'h00c0, "leftReset");
		rdc(8'hcc, 32'h00c0, "rightReset");
		rdc(8'hd4, 32'h0040, "rateReset");
		rdc(8'h00, 32'h0000, "unmapped");
		wr(8'hc0, 16'h303b);
		rdc(8'hc0, 32'h303b, "ctrlBack");
		chk("mono", mono, 32'h1);
		chk("ratio", ratio, 32'h1);
		chk("fast", fast, 32'h1);
		for (int k = 0; k < 4; k++)
		begin
			wr(8'hc0, 16'(k << 4));
			chk("deemph", deemphasis_sel, 32'(k));
		end
		wr(8'hc0, 16'h0000);
		smp(16'h1234, 16'h5678, 16'h0000, 16'h0000);
		wr(8'hc8, 16'h80c0);
		wr(8'hcc, 16'h80c0);
		smp(16'h1234, 16'hff00, 16'h1234, 16'hff00);
		wr(8'hc0, 16'h0030);
		smp(16'h2234, 16'hff00, 16'h1e34, 16'hff00);
		wr(8'hc0, 16'h0003);
		smp(16'h1234, 16'h8000, 16'hedcc, 16'h7fff);
		wr(8'hc0, 16'h2000);
		smp(16'hf000, 16'h0200, 16'hf900, 16'hf900);
		wr(8'hc0, 16'h0000);
		wr(8'hc8, 16'h80b0);
		rdc(8'hc8, 32'h80b0, "leftPending");
		rdc(8'hdc, 32'h0004, "statusPend");
		smp(16'h4000, 16'h4000, 16'h4000, 16'h4000);
		wr(8'hcc, 16'h81c0);
		smp(16'h4000, 16'h4000, 16'h2013, 16'h4000);
		rdc(8'hdc, 32'h0000, "statusDone");
		wr(8'hc8, 16'h8100);
		smp(16'h0100, 16'h0100, 16'h0000, 16'h0100);
		wr(8'hcc, 16'h00c0);
		smp(16'h0100, 16'h0200, 16'h0000, 16'h0000);
		master <= 1'b1;
		fc(16'h0008, 40);
		fc(16'h0808, 8);
		fc(16'h0803, 8);
		fc(16'h0809, 9);
		end_of_test();
	end
endmodule
